/* common/ffmr_pkg.sv */
// Register map, field positions, reset values and timing for the fault flag and mask bank
package ffmr_pkg;
   localparam int unsigned REG_W               = 16;
   localparam int unsigned CMD_W               = 8;
   localparam logic [7:0]  CMD_FAULT_FLAGS     = 8'hD0;
   localparam logic [7:0]  CMD_FAULT_MASK      = 8'hD1;
   localparam logic [7:0]  CMD_FAULT_RESPONSE  = 8'hD2;
   localparam logic [15:0] FLAGS_RESET         = 16'h0000;
   localparam logic [15:0] MASK_RESET          = 16'h0049;
   localparam logic [15:0] RESP_RESET          = 16'h0000;
   localparam logic [15:0] RESP_STRAP_HIGH     = 16'h03FF;
   localparam logic [15:0] FLAGS_USED          = 16'h03FF;
   localparam logic [15:0] MASK_WRITABLE       = 16'h03FC;
   localparam logic [15:0] RESP_USED           = 16'h03FF;
   localparam int unsigned BIT_COMM            = 0;
   localparam int unsigned BIT_TEMP_WARN       = 1;
   localparam int unsigned BIT_IN_OV           = 2;
   localparam int unsigned BIT_TEMP_FAULT      = 3;
   localparam int unsigned BIT_AVG_OC          = 4;
   localparam int unsigned BIT_PEAK_OC         = 5;
   localparam int unsigned BIT_OUT_UV          = 6;
   localparam int unsigned BIT_OUT_OV          = 7;
   localparam int unsigned BIT_LOOP_SHORT      = 8;
   localparam int unsigned BIT_PLL_MIN         = 9;
   localparam int unsigned PROT_LO             = 2;
   localparam int unsigned PROT_HI             = 9;
   localparam int unsigned SYNC_W              = 12;
   localparam int unsigned PIN_PEAK0           = 4;
   localparam int unsigned PIN_PEAK1           = 5;
   localparam int unsigned PIN_ENABLE          = 10;
   localparam int unsigned PIN_STRAP           = 11;
   localparam logic [2:0]  STRAP_SETTLE        = 3'h4;
   localparam int unsigned HICCUP_TIME_MS      = 500;
   localparam int unsigned CLK_HZ              = 10_000_000;
   localparam int unsigned HICCUP_CYCLES_DEF   = HICCUP_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned TIMER_W             = 23;
   typedef logic [15:0] ffmr_word_t;
   typedef enum logic [2:0] {
      ST_RUN     = 3'b001,
      ST_HICCUP  = 3'b010,
      ST_LATCHED = 3'b100
   } ffmr_prot_e;
endpackage

/* common/ffmr_timer_if.sv */
// Start and done handshake between the protection sequencer and the hiccup timer
`timescale 1ns/1ns
interface ffmr_timer_if;
   logic start;
   logic busy;
   logic done;
   modport ctrl  (output start, input busy, input done);
   modport timer (input start, output busy, output done);
endinterface

/* hdl/ffmr_fault_bank.sv */
// Fault flag, fault mask and response registers with the protection sequencer
//
// How it works
// - Flag bits stick at one once set
// - Flags record past faults, not present state
// - Flags use bits 9..0; 15..10 read zero
// - Bit 0 set on unsupported command or PEC
// - Bit 1 set by thermistor warning comparator
// - Bit 2 set by input overvoltage detector
// - Bit 3 set by thermistor fault comparator
// - Bit 4 set by average overcurrent detector
// - Bit 5 set by any phase peak overcurrent
// - Bit 6 set by output undervoltage
// - Bit 7 set by output overvoltage
// - Bit 8 set by loop compensation short
// - Bit 9 set by loop minimum frequency
// - Masked fault: no action, keep switching
// - Unmasked fault in bits 9..2: hiccup or latch-off
// - Mask bit matches flag bit position
// - Mask resets to 0049h
// - Mask bit 3 set after reset
// - Response bit picks hiccup or latch; strap default
// - Hiccup: stop, wait, soft-start, repeat
// - Alert output low when a flag sets
// - Latch-off holds until enable toggles
`timescale 1ns/1ns
module ffmr_fault_bank #(
   parameter int unsigned HICCUP_CYCLES = ffmr_pkg::HICCUP_CYCLES_DEF
) (
   input  wire logic                     CORE_CLK,
   input  wire logic                     RESET_N,
   input  wire logic [ffmr_pkg::CMD_W-1:0] CMD_CODE,
   input  wire logic                     CMD_WRITE,
   input  wire logic [ffmr_pkg::REG_W-1:0] CMD_WDATA,
   input  wire logic                     CMD_READ,
   output      logic [ffmr_pkg::REG_W-1:0] CMD_RDATA,
   output      logic                     CMD_RVALID,
   input  wire logic                     COMM_UNSUPPORTED,
   input  wire logic                     COMM_PEC_ERROR,
   input  wire logic                     EXT_TEMP_WARNING,
   input  wire logic                     INPUT_OVERVOLTAGE,
   input  wire logic                     EXT_TEMP_FAULT,
   input  wire logic                     AVERAGE_OVERCURRENT,
   input  wire logic [1:0]               PHASE_CURRENT_SENSE,
   input  wire logic                     OUTPUT_UNDERVOLTAGE,
   input  wire logic                     OUTPUT_OVERVOLTAGE,
   input  wire logic                     LOOP_COMP_SHORT,
   input  wire logic                     PLL_MIN_FREQ,
   input  wire logic                     ENABLE_PIN,
   input  wire logic                     RESPONSE_STRAP_PIN,
   output      logic                     ALERT_OUT_N,
   output      logic                     SWITCH_ENABLE,
   output      logic                     SOFT_START_REQ,
   output      logic                     HICCUP_ACTIVE,
   output      logic                     LATCHED_OFF
);
   import ffmr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] pin_sync;
   logic [REG_W-1:0]  fault_det;
   logic              comm_event;
   logic              enable_level;
   logic              strap_level;

   ffmr_word_t        flags_reg;
   ffmr_word_t        flags_next;
   ffmr_word_t        mask_reg;
   ffmr_word_t        mask_next;
   ffmr_word_t        resp_reg;
   ffmr_word_t        resp_next;
   ffmr_word_t        flag_clear;
   ffmr_word_t        rdata_reg;
   ffmr_word_t        rdata_next;
   ffmr_word_t        rd_mux;
   logic              rvalid_reg;

   logic              hit_flags;
   logic              hit_mask;
   logic              hit_resp;
   logic              wr_flags;
   logic              wr_mask;
   logic              wr_resp;

   logic [2:0]        settle_reg;
   logic [2:0]        settle_next;
   logic              strap_done_reg;
   logic              strap_done_next;
   logic              strap_load;

   logic [PROT_HI:PROT_LO] prot_active;
   logic              prot_any;
   logic              prot_latch;

   ffmr_prot_e        state_reg;
   ffmr_prot_e        state_next;
   logic              tstart_reg;
   logic              tstart_next;
   logic              ss_reg;
   logic              ss_next;
   logic              en_low_seen_reg;
   logic              en_low_seen_next;
   logic              en_prev_reg;
   logic              en_rise;
   logic              alert_n_reg;
   logic              alert_n_next;
   logic              sw_en_reg;
   logic              sw_en_next;
   logic              hic_reg;
   logic              lat_reg;

   ffmr_timer_if      tmr_if ();

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and hiccup timer

   assign pin_raw = {RESPONSE_STRAP_PIN,
                     ENABLE_PIN,
                     PLL_MIN_FREQ,
                     LOOP_COMP_SHORT,
                     OUTPUT_OVERVOLTAGE,
                     OUTPUT_UNDERVOLTAGE,
                     PHASE_CURRENT_SENSE[1],
                     PHASE_CURRENT_SENSE[0],
                     AVERAGE_OVERCURRENT,
                     EXT_TEMP_FAULT,
                     INPUT_OVERVOLTAGE,
                     EXT_TEMP_WARNING};

   ffmr_pin_sync u_sync (
      .clk     (CORE_CLK),
      .rst_n   (RESET_N),
      .pin_in  (pin_raw),
      .pin_out (pin_sync)
   );

   ffmr_hiccup_timer #(
      .CYCLES (HICCUP_CYCLES)
   ) u_timer (
      .clk   (CORE_CLK),
      .rst_n (RESET_N),
      .tmr   (tmr_if.timer)
   );

   assign tmr_if.start = tstart_reg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Fault detections in flag bit order

   // Command faults come from the transaction engine on this clock, so no synchroniser
   assign comm_event = COMM_UNSUPPORTED | COMM_PEC_ERROR;

   assign fault_det[BIT_COMM]       = comm_event;
   assign fault_det[BIT_TEMP_WARN]  = pin_sync[0];
   assign fault_det[BIT_IN_OV]      = pin_sync[1];
   assign fault_det[BIT_TEMP_FAULT] = pin_sync[2];
   assign fault_det[BIT_AVG_OC]     = pin_sync[3];
   assign fault_det[BIT_PEAK_OC]    = pin_sync[PIN_PEAK0] | pin_sync[PIN_PEAK1];
   assign fault_det[BIT_OUT_UV]     = pin_sync[6];
   assign fault_det[BIT_OUT_OV]     = pin_sync[7];
   assign fault_det[BIT_LOOP_SHORT] = pin_sync[8];
   assign fault_det[BIT_PLL_MIN]    = pin_sync[9];
   assign fault_det[15:10]          = 6'h00;

   assign enable_level = pin_sync[PIN_ENABLE];
   assign strap_level  = pin_sync[PIN_STRAP];

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Command decode

   assign hit_flags = (CMD_CODE == CMD_FAULT_FLAGS);
   assign hit_mask  = (CMD_CODE == CMD_FAULT_MASK);
   assign hit_resp  = (CMD_CODE == CMD_FAULT_RESPONSE);
   assign wr_flags  = CMD_WRITE & hit_flags;
   assign wr_mask   = CMD_WRITE & hit_mask;
   assign wr_resp   = CMD_WRITE & hit_resp & strap_done_reg;

   // Writing a one clears that flag; writing zero leaves it alone
   assign flag_clear = wr_flags ? (CMD_WDATA & FLAGS_USED) : 16'h0000;

   assign rd_mux = hit_flags ? (flags_reg & FLAGS_USED) :
                   hit_mask  ? mask_reg :
                   hit_resp  ? (resp_reg & RESP_USED) :
                   16'h0000;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Sticky flags, one per bit; a detection in the clearing cycle wins

   genvar b;
   generate
      for (b = 0; b < REG_W; b++) begin : g_flag
         assign flags_next[b] = FLAGS_USED[b] &
                                (fault_det[b] | (flags_reg[b] & ~flag_clear[b]));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Mask and response registers

   // Bits 1..0 of the mask keep their reset value and bits 15..10 stay zero
   assign mask_next = wr_mask ?
                      ((CMD_WDATA & MASK_WRITABLE) | (MASK_RESET & ~MASK_WRITABLE)) :
                      mask_reg;

   // Strap is taken one edge after the synchroniser output has settled past reset
   assign settle_next     = (settle_reg == STRAP_SETTLE) ? settle_reg : settle_reg + 3'h1;
   assign strap_load      = (settle_reg == STRAP_SETTLE) & ~strap_done_reg;
   assign strap_done_next = strap_done_reg | strap_load;

   assign resp_next = strap_load ? (strap_level ? RESP_STRAP_HIGH : RESP_RESET) :
                      wr_resp    ? (CMD_WDATA & RESP_USED) :
                      resp_reg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Protection decision

   assign prot_active = fault_det[PROT_HI:PROT_LO] & ~mask_reg[PROT_HI:PROT_LO];
   assign prot_any    = |prot_active;
   // Any active fault set to latch-off overrides hiccup for the others
   assign prot_latch  = |(prot_active & ~resp_reg[PROT_HI:PROT_LO]);
   assign en_rise     = enable_level & ~en_prev_reg;

   always_comb begin
      state_next       = state_reg;
      tstart_next      = 1'b0;
      ss_next          = 1'b0;
      en_low_seen_next = en_low_seen_reg;
      case (state_reg)
         ST_RUN: begin
            en_low_seen_next = 1'b0;
            if (strap_done_reg && enable_level && prot_any) begin
               if (prot_latch) begin
                  state_next = ST_LATCHED;
               end else begin
                  state_next  = ST_HICCUP;
                  tstart_next = 1'b1;
               end
            end else if (strap_done_reg && en_rise) begin
               ss_next = 1'b1;
            end
         end
         ST_HICCUP: begin
            if (prot_latch) begin
               state_next = ST_LATCHED;
            end else if (tmr_if.done) begin
               if (prot_any) begin
                  tstart_next = 1'b1;
               end else begin
                  state_next = ST_RUN;
                  ss_next    = enable_level;
               end
            end
         end
         ST_LATCHED: begin
            // Fault removal alone never restarts; only a low-then-high enable does
            if (!enable_level) begin
               en_low_seen_next = 1'b1;
            end else if (en_low_seen_reg) begin
               state_next       = ST_RUN;
               ss_next          = 1'b1;
               en_low_seen_next = 1'b0;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   // Switching runs only in the run state, so masked faults never stop it
   assign sw_en_next   = (state_next == ST_RUN) & enable_level & strap_done_reg;
   assign alert_n_next = ~(|flags_next);
   assign rdata_next   = CMD_READ ? rd_mux : rdata_reg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         flags_reg      <= FLAGS_RESET;
         mask_reg       <= MASK_RESET;
         resp_reg       <= RESP_RESET;
         settle_reg     <= 3'h0;
         strap_done_reg <= 1'b0;
      end else begin
         flags_reg      <= flags_next;
         mask_reg       <= mask_next;
         resp_reg       <= resp_next;
         settle_reg     <= settle_next;
         strap_done_reg <= strap_done_next;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         state_reg       <= ST_RUN;
         tstart_reg      <= 1'b0;
         ss_reg          <= 1'b0;
         en_low_seen_reg <= 1'b0;
         en_prev_reg     <= 1'b0;
      end else begin
         state_reg       <= state_next;
         tstart_reg      <= tstart_next;
         ss_reg          <= ss_next;
         en_low_seen_reg <= en_low_seen_next;
         en_prev_reg     <= enable_level;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         rdata_reg   <= 16'h0000;
         rvalid_reg  <= 1'b0;
         alert_n_reg <= 1'b1;
         sw_en_reg   <= 1'b0;
         hic_reg     <= 1'b0;
         lat_reg     <= 1'b0;
      end else begin
         rdata_reg   <= rdata_next;
         rvalid_reg  <= CMD_READ;
         alert_n_reg <= alert_n_next;
         sw_en_reg   <= sw_en_next;
         hic_reg     <= (state_next == ST_HICCUP);
         lat_reg     <= (state_next == ST_LATCHED);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign CMD_RDATA      = rdata_reg;
   assign CMD_RVALID     = rvalid_reg;
   assign ALERT_OUT_N    = alert_n_reg;
   assign SWITCH_ENABLE  = sw_en_reg;
   assign SOFT_START_REQ = ss_reg;
   assign HICCUP_ACTIVE  = hic_reg;
   assign LATCHED_OFF    = lat_reg;
endmodule

/* hdl/ffmr_hiccup_timer.sv */
// Down-counter that times the pause between hiccup restarts
`timescale 1ns/1ns
module ffmr_hiccup_timer #(
   parameter int unsigned CYCLES = ffmr_pkg::HICCUP_CYCLES_DEF
) (
   input  wire logic   clk,
   input  wire logic   rst_n,
   ffmr_timer_if.timer tmr
);
   import ffmr_pkg::*;

   localparam logic [TIMER_W-1:0] LOAD = TIMER_W'(CYCLES - 1);

   logic [TIMER_W-1:0] count_reg;
   logic [TIMER_W-1:0] count_next;
   logic               busy_reg;
   logic               busy_next;
   logic               done_reg;
   logic               done_next;

   // A new start reloads the count, so a fault still present when the pause ends starts a full new pause
   always_comb begin
      count_next = count_reg;
      busy_next  = busy_reg;
      done_next  = 1'b0;
      if (tmr.start) begin
         count_next = LOAD;
         busy_next  = 1'b1;
      end else if (busy_reg) begin
         if (count_reg == '0) begin
            busy_next = 1'b0;
            done_next = 1'b1;
         end else begin
            count_next = count_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_reg <= '0;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         count_reg <= count_next;
         busy_reg  <= busy_next;
         done_reg  <= done_next;
      end
   end

   assign tmr.busy = busy_reg;
   assign tmr.done = done_reg;
endmodule

/* hdl/ffmr_pin_sync.sv */
// Three-stage synchroniser for the comparator, enable and strap pins
`timescale 1ns/1ns
module ffmr_pin_sync (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [ffmr_pkg::SYNC_W-1:0] pin_in,
   output      logic [ffmr_pkg::SYNC_W-1:0] pin_out
);
   import ffmr_pkg::*;

   logic [SYNC_W-1:0] s1_reg;
   logic [SYNC_W-1:0] s2_reg;
   logic [SYNC_W-1:0] s3_reg;
   logic [SYNC_W-1:0] out_reg;

   // A change counts only once the second and third stages agree
   genvar i;
   generate
      for (i = 0; i < SYNC_W; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               s1_reg[i]  <= 1'b0;
               s2_reg[i]  <= 1'b0;
               s3_reg[i]  <= 1'b0;
               out_reg[i] <= 1'b0;
            end else begin
               s1_reg[i] <= pin_in[i];
               s2_reg[i] <= s1_reg[i];
               s3_reg[i] <= s2_reg[i];
               if (s2_reg[i] == s3_reg[i]) begin
                  out_reg[i] <= s3_reg[i];
               end
            end
         end
      end
   endgenerate

   assign pin_out = out_reg;
endmodule

/* tb/ffmr_fault_bank_checker.sv */
// Port-level checks of the fault flag and mask bank
`timescale 1ns/1ns
module ffmr_fault_bank_checker #(
   parameter int unsigned HICCUP_CYCLES = 20
) (
   input wire logic                       CORE_CLK,
   input wire logic                       RESET_N,
   input wire logic [ffmr_pkg::CMD_W-1:0] CMD_CODE,
   input wire logic                       CMD_WRITE,
   input wire logic                       CMD_READ,
   input wire logic [ffmr_pkg::REG_W-1:0] CMD_RDATA,
   input wire logic                       CMD_RVALID,
   input wire logic                       ENABLE_PIN,
   input wire logic                       ALERT_OUT_N,
   input wire logic                       SWITCH_ENABLE,
   input wire logic                       SOFT_START_REQ,
   input wire logic                       HICCUP_ACTIVE,
   input wire logic                       LATCHED_OFF
);
   import ffmr_pkg::*;
   int hic_cnt;
   // Counts the pause so a short hiccup timer is caught
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N || !HICCUP_ACTIVE) begin
         hic_cnt <= 0;
      end else begin
         hic_cnt <= hic_cnt + 1;
      end
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_flag_read;
      CMD_RVALID && $past(CMD_READ) && $past(CMD_CODE) == CMD_FAULT_FLAGS;
   endsequence
   sequence s_held_low;
      (!ENABLE_PIN)[*5] ##0 LATCHED_OFF;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   a_unused_zero: assert property (CMD_RVALID |-> CMD_RDATA[15:10] == 6'h00)
      else $error("unused bits not zero");
   a_mask_fixed: assert property (
      CMD_RVALID && $past(CMD_CODE) == CMD_FAULT_MASK |-> CMD_RDATA[1:0] == 2'b01)
      else $error("mask low bits wrong");
   a_alert_flags: assert property (s_flag_read |-> (CMD_RDATA != 0) == !$past(ALERT_OUT_N))
      else $error("alert disagrees with flags");
   a_flags_sticky: assert property (
      !ALERT_OUT_N && !(CMD_WRITE && CMD_CODE == CMD_FAULT_FLAGS) |=> !ALERT_OUT_N)
      else $error("flag dropped without clear");
   a_no_switch_prot: assert property (SWITCH_ENABLE |-> !HICCUP_ACTIVE && !LATCHED_OFF)
      else $error("switching during protection");
   a_one_mode: assert property (!(HICCUP_ACTIVE && LATCHED_OFF))
      else $error("hiccup and latch together");
   a_hiccup_wait: assert property ($fell(HICCUP_ACTIVE) && !LATCHED_OFF |-> hic_cnt >= HICCUP_CYCLES)
      else $error("hiccup pause too short");
   a_restart_pulse: assert property (SOFT_START_REQ |-> SWITCH_ENABLE ##1 !SOFT_START_REQ)
      else $error("bad soft start pulse");
   a_latch_hold: assert property (s_held_low |=> LATCHED_OFF)
      else $error("latch left without enable");
endmodule

/* tb/ffmr_host_model.sv */
// Host stand-in that drives the command strobes of the fault bank
`timescale 1ns/1ns
module ffmr_host_model (
   input  wire logic                       clk,
   output      logic [ffmr_pkg::CMD_W-1:0] cmd_code,
   output      logic                       cmd_write,
   output      logic [ffmr_pkg::REG_W-1:0] cmd_wdata,
   output      logic                       cmd_read
);
   import ffmr_pkg::*;
   initial begin
      cmd_code = 8'h00;
      cmd_write = 1'b0;
      cmd_wdata = 16'h0000;
      cmd_read = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One strobe cycle, then the data bus goes stale so it is never trusted
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      cmd_code <= c;
      cmd_wdata <= d;
      cmd_write <= 1'b1;
      @(posedge clk);
      cmd_write <= 1'b0;
      cmd_wdata <= ~d;
   endtask
   // One read strobe cycle for the given command code, with no wait for an alert
   task automatic rd(input logic [7:0] c);
      @(posedge clk);
      cmd_code <= c;
      cmd_read <= 1'b1;
      @(posedge clk);
      cmd_read <= 1'b0;
   endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the fault flag and mask bank
`timescale 1ns/1ns
module testbench;
   import ffmr_pkg::*;
   localparam int unsigned HC = 20;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [9:0] fl = 10'h000;
   logic pec = 1'b0;
   logic [1:0] ph = 2'h0;
   logic en = 1'b1;
   logic strap = 1'b1;
   logic [7:0] code;
   logic wr_s, rd_s, rvalid, alert_n, sw_en, ss_req, hic, latched;
   logic [15:0] wdata, rdata, flags, w;
   logic [23:0] expq[$];
   logic [23:0] it;
   int miscompares = 0;
   int compares = 0;
   int cyc = 0;
   always #50 core_clk = ~core_clk;
   ffmr_host_model host_u (.clk(core_clk), .cmd_code(code), .cmd_write(wr_s),
      .cmd_wdata(wdata), .cmd_read(rd_s));
   ffmr_fault_bank #(.HICCUP_CYCLES(HC)) dut_u (.CORE_CLK(core_clk), .RESET_N(reset_n),
      .CMD_CODE(code), .CMD_WRITE(wr_s), .CMD_WDATA(wdata), .CMD_READ(rd_s),
      .CMD_RDATA(rdata), .CMD_RVALID(rvalid), .COMM_UNSUPPORTED(fl[0]), .COMM_PEC_ERROR(pec),
      .EXT_TEMP_WARNING(fl[1]), .INPUT_OVERVOLTAGE(fl[2]), .EXT_TEMP_FAULT(fl[3]),
      .AVERAGE_OVERCURRENT(fl[4]), .PHASE_CURRENT_SENSE(ph), .OUTPUT_UNDERVOLTAGE(fl[6]),
      .OUTPUT_OVERVOLTAGE(fl[7]), .LOOP_COMP_SHORT(fl[8]), .PLL_MIN_FREQ(fl[9]),
      .ENABLE_PIN(en), .RESPONSE_STRAP_PIN(strap), .ALERT_OUT_N(alert_n),
      .SWITCH_ENABLE(sw_en), .SOFT_START_REQ(ss_req), .HICCUP_ACTIVE(hic), .LATCHED_OFF(latched));
   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s exp %b got %b", n, e, g);
      end
   endtask
   // Read results are noted here and matched by the watcher below
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      expq.push_back({c, e});
      host_u.rd(c);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      host_u.wr(c, d);
   endtask
   task automatic hit(input int k, input int len);
      @(posedge core_clk);
      if (k == 10) begin
         pec <= 1'b1;
      end else if (k == 5) begin
         ph <= 2'($urandom_range(3, 1));
      end else begin
         fl[k] <= 1'b1;
      end
      repeat (len) @(posedge core_clk);
      pec <= 1'b0;
      ph <= 2'h0;
      fl <= 10'h000;
      repeat (6) @(posedge core_clk);
   endtask
   task automatic wait_ss();
      int n;
      n = 0;
      while (ss_req !== 1'b1 && n < 300) begin
         @(posedge core_clk);
         n++;
      end
      chk1("soft_start", 1'b1, ss_req);
   endtask
   // Long settle so synchronisers and the strap load are done
   task automatic do_reset();
      reset_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      flags = 16'h0000;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (rvalid === 1'b1) begin
         compares++;
         it = (expq.size() > 0) ? expq.pop_front() : 24'hxx_xxxx;
         if (rdata !== it[15:0]) begin
            miscompares++;
            $display("BAD reg %h exp %h got %h", it[23:16], it[15:0], rdata);
         end
      end
      if (cyc == 5000) begin
         miscompares++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(13217));
      do_reset();
      rd(CMD_FAULT_FLAGS, 16'h0000);
      rd(CMD_FAULT_MASK, 16'h0049);
      rd(8'h55, 16'h0000);
      rd(CMD_FAULT_RESPONSE, 16'h03FF);
      wr(CMD_FAULT_MASK, 16'hFFFF);
      rd(CMD_FAULT_MASK, 16'h03FD);
      for (int k = 0; k <= 10; k++) begin
         hit(k, 6);
         flags[k % 10] = 1'b1;
         rd(CMD_FAULT_FLAGS, flags);
         chk1("alert_n", 1'b0, alert_n);
         chk1("switch", 1'b1, sw_en);
      end
      w = 16'($urandom) | 16'hFC00;
      wr(CMD_FAULT_FLAGS, w);
      flags = flags & ~w;
      rd(CMD_FAULT_FLAGS, flags);
      wr(CMD_FAULT_FLAGS, 16'hFFFF);
      rd(CMD_FAULT_FLAGS, 16'h0000);
      chk1("alert_n", 1'b1, alert_n);
      wr(CMD_FAULT_MASK, 16'h0000);
      rd(CMD_FAULT_MASK, 16'h0001);
      hit(2, 8);
      chk1("hiccup", 1'b1, hic);
      chk1("switch", 1'b0, sw_en);
      wait_ss();
      chk1("switch", 1'b1, sw_en);
      wr(CMD_FAULT_RESPONSE, 16'h0000);
      rd(CMD_FAULT_RESPONSE, 16'h0000);
      hit(7, 8);
      repeat (40) @(posedge core_clk);
      chk1("latched", 1'b1, latched);
      chk1("switch", 1'b0, sw_en);
      rd(CMD_FAULT_FLAGS, 16'h0084);
      en <= 1'b0;
      repeat (8) @(posedge core_clk);
      en <= 1'b1;
      wait_ss();
      chk1("latched", 1'b0, latched);
      strap <= 1'b0;
      do_reset();
      rd(CMD_FAULT_MASK, 16'h0049);
      rd(CMD_FAULT_RESPONSE, 16'h0000);
      for (int k = 3; k <= 6; k += 3) begin
         hit(k, 6);
         chk1("switch", 1'b1, sw_en);
      end
      repeat (4) @(posedge core_clk);
      conclude();
   end
endmodule
bind ffmr_fault_bank ffmr_fault_bank_checker #(.HICCUP_CYCLES(HICCUP_CYCLES)) chk_u (
   .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CMD_CODE(CMD_CODE), .CMD_WRITE(CMD_WRITE),
   .CMD_READ(CMD_READ), .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID),
   .ENABLE_PIN(ENABLE_PIN), .ALERT_OUT_N(ALERT_OUT_N), .SWITCH_ENABLE(SWITCH_ENABLE),
   .SOFT_START_REQ(SOFT_START_REQ), .HICCUP_ACTIVE(HICCUP_ACTIVE), .LATCHED_OFF(LATCHED_OFF));
